/* File: rtl/rts_pkg.sv */
// Constants shared by both ends of the tag and sequence return path.
// Assumes both ends run on one clock and meet through rts_if.
// Summary of operation
// RULE_01 - Core-managed tags reported on 10-bit output
// RULE_02 - First tag valid only while its strobe
// RULE_03 - Client captures tags to match completions
// RULE_04 - Client may issue requests before tags return
// RULE_05 - Tags returned and paired in transfer order
// RULE_06 - First tag output holds earlier request
// RULE_07 - Second tag output valid with own strobe
// RULE_08 - Client supplies 6-bit sequence per request
// RULE_09 - Sequence echoed once past completion overtaking
// RULE_10 - Second sequence output carries extra echo
// RULE_11 - First sequence strobe pulses one cycle
// RULE_12 - Second sequence strobe pulses one cycle
// RULE_13 - Sequence echo use optional for client
// RULE_14 - Address-space-id option shares sideband bits
// RULE_15 - Transfer only when valid and ready
// RULE_16 - Tag strobe zero none, one present
// RULE_17 - Client tag mode keeps strobes low
// RULE_18 - Reset clears strobes and empties queues
package rts_pkg;
  localparam int TAG_W = 10;
  localparam int SEQ_W = 6;
  localparam int SIDEBAND_W = 183;
  localparam int SHARED_HI = 182;
  localparam int SHARED_LO = 137;
  localparam int PIPE_LAT = 3;
  localparam int QUEUE_DEPTH = 16;
  localparam logic [TAG_W-1:0] TAG_RST = 10'h000;
  localparam logic [SEQ_W-1:0] SEQ_RST = 6'h00;
endpackage

/* File: rtl/rts_if.sv */
// Interface joining the core end and the client end of the return path.
// Assumes one clock; the testbench drives clk and reset.
`timescale 1ns/1ns
interface rts_if
  import rts_pkg::*;
(
  input wire logic clk,
  input wire logic reset
);
  logic req_valid; // Client has a request beat
  logic req_ready; // Core accepts the beat
  logic req_non_posted; // Beat starts a Non-Posted request
  logic [SEQ_W-1:0] req_seq_in_a; // Client sequence number
  logic [SIDEBAND_W-1:0] request_stream_sideband; // Sideband
  logic [TAG_W-1:0] alloc_tag_out_a; // Earlier tag
  logic [TAG_W-1:0] alloc_tag_out_b; // Later tag
  logic alloc_tag_strobe_a;
  logic alloc_tag_strobe_b;
  logic [SEQ_W-1:0] echo_seq_out_a;
  logic [SEQ_W-1:0] echo_seq_out_b;
  logic echo_seq_strobe_a;
  logic echo_seq_strobe_b;
  modport core (input clk, reset, req_valid, req_non_posted, req_seq_in_a, request_stream_sideband,
    output req_ready, alloc_tag_out_a, alloc_tag_out_b, alloc_tag_strobe_a, alloc_tag_strobe_b,
    echo_seq_out_a, echo_seq_out_b, echo_seq_strobe_a, echo_seq_strobe_b);
  modport client (input clk, reset, req_ready, alloc_tag_out_a, alloc_tag_out_b, alloc_tag_strobe_a,
    alloc_tag_strobe_b, echo_seq_out_a, echo_seq_out_b, echo_seq_strobe_a, echo_seq_strobe_b,
    output req_valid, req_non_posted, req_seq_in_a, request_stream_sideband);
endinterface

/* File: rtl/rts_core.sv */
// Core end: accepts request beats, allocates tags, returns tags and sequence echoes.
// Assumes the client holds valid and data steady while ready is low.
`timescale 1ns/1ns
module rts_core
  import rts_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH, // Queue depth, power of two
  parameter int LAT = PIPE_LAT // Cycles until a request can't be passed
) (
  rts_if.core bus,
  input wire logic client_tag_on, // Client manages its own tags
  input wire logic addr_space_id_capability_on, // Sideband top bits are shared
  input wire logic [SHARED_HI-SHARED_LO:0] cfg_shared_in, // Shared config value
  output logic [SHARED_HI-SHARED_LO:0] cfg_shared_out // Shared bits seen by config
);
  localparam int AW = $clog2(DEPTH);
  // Tag queue and sequence queue storage
  logic [TAG_W-1:0] tag_mem [DEPTH];
  logic [SEQ_W-1:0] seq_mem [DEPTH];
  logic [AW:0] tq_wr, tq_rd, next_tq_wr, next_tq_rd;
  logic [AW:0] sq_wr, sq_rd, next_sq_wr, next_sq_rd;
  logic [LAT-1:0] sq_delay, next_sq_delay; // Pipeline position of head sequence
  logic [TAG_W-1:0] tag_ctr, next_tag_ctr; // Next tag to hand out
  logic take; // Beat transferred
  logic [TAG_W-1:0] next_tag_a, next_tag_b;
  logic [SEQ_W-1:0] next_seq_a, next_seq_b;
  logic next_tstb_a, next_tstb_b, next_sstb_a, next_sstb_b;
  logic [AW:0] t_cnt, s_cnt;
  wire clk_w = bus.clk; // Local copy of the interface clock
  wire rst_w = bus.reset; // Local copy of the interface reset

  // Queue index wrap
  function automatic logic [AW-1:0] idx(input logic [AW:0] p);
    return p[AW-1:0];
  endfunction

  assign take = bus.req_valid && bus.req_ready; // RULE_15
  assign t_cnt = tq_wr - tq_rd;
  assign s_cnt = sq_wr - sq_rd;

  // Next-state for queues, strobes and outputs
  always_comb begin
    next_tq_wr = tq_wr;
    next_tq_rd = tq_rd;
    next_sq_wr = sq_wr;
    next_sq_rd = sq_rd;
    next_tag_ctr = tag_ctr;
    next_sq_delay = sq_delay;
    next_tag_a = bus.alloc_tag_out_a;
    next_tag_b = bus.alloc_tag_out_b;
    next_seq_a = bus.echo_seq_out_a;
    next_seq_b = bus.echo_seq_out_b;
    next_tstb_a = 1'b0;
    next_tstb_b = 1'b0;
    next_sstb_a = 1'b0;
    next_sstb_b = 1'b0;
    // Pop up to two tags, oldest on output a
    if (!client_tag_on && t_cnt != '0) begin // RULE_17
      next_tag_a = tag_mem[idx(tq_rd)]; // RULE_01 RULE_05 RULE_06
      next_tstb_a = 1'b1; // RULE_02 RULE_16
      next_tq_rd = tq_rd + 1'b1;
      if (t_cnt > 1) begin
        next_tag_b = tag_mem[idx(tq_rd + 1'b1)]; // RULE_06 RULE_07
        next_tstb_b = 1'b1; // RULE_07 RULE_16
        next_tq_rd = tq_rd + 2'd2;
      end
    end
    // Age head sequence; echo once it is past the overtaking point
    if (s_cnt != '0) begin
      next_sq_delay = {sq_delay[LAT-2:0], 1'b1};
      if (sq_delay[LAT-1]) begin // RULE_09
        next_seq_a = seq_mem[idx(sq_rd)];
        next_sstb_a = 1'b1; // RULE_11
        next_sq_rd = sq_rd + 1'b1;
        if (s_cnt > 1) begin // RULE_10
          next_seq_b = seq_mem[idx(sq_rd + 1'b1)];
          next_sstb_b = 1'b1; // RULE_12
          next_sq_rd = sq_rd + 2'd2;
        end
        next_sq_delay = '0;
      end
    end
    // Enqueue a transferred request
    if (take) begin
      next_sq_wr = sq_wr + 1'b1;
      if (bus.req_non_posted && !client_tag_on) begin
        next_tq_wr = tq_wr + 1'b1;
        next_tag_ctr = tag_ctr + 1'b1;
      end
    end
  end

  // Register state; reset empties queues and drops strobes
  always_ff @(posedge clk_w or posedge rst_w) begin
    if (rst_w) begin // RULE_18
      tq_wr <= '0;
      tq_rd <= '0;
      sq_wr <= '0;
      sq_rd <= '0;
      sq_delay <= '0;
      tag_ctr <= TAG_RST;
      bus.alloc_tag_out_a <= TAG_RST;
      bus.alloc_tag_out_b <= TAG_RST;
      bus.echo_seq_out_a <= SEQ_RST;
      bus.echo_seq_out_b <= SEQ_RST;
      bus.alloc_tag_strobe_a <= 1'b0;
      bus.alloc_tag_strobe_b <= 1'b0;
      bus.echo_seq_strobe_a <= 1'b0;
      bus.echo_seq_strobe_b <= 1'b0;
      bus.req_ready <= 1'b0;
      cfg_shared_out <= '0;
    end else begin
      tq_wr <= next_tq_wr;
      tq_rd <= next_tq_rd;
      sq_wr <= next_sq_wr;
      sq_rd <= next_sq_rd;
      sq_delay <= next_sq_delay;
      tag_ctr <= next_tag_ctr;
      bus.alloc_tag_out_a <= next_tag_a;
      bus.alloc_tag_out_b <= next_tag_b;
      bus.echo_seq_out_a <= next_seq_a;
      bus.echo_seq_out_b <= next_seq_b;
      bus.alloc_tag_strobe_a <= next_tstb_a;
      bus.alloc_tag_strobe_b <= next_tstb_b;
      bus.echo_seq_strobe_a <= next_sstb_a;
      bus.echo_seq_strobe_b <= next_sstb_b;
      // Stall while either queue may overflow next cycle
      bus.req_ready <= (next_tq_wr - next_tq_rd) < (AW+1)'(DEPTH - 1)
        && (next_sq_wr - next_sq_rd) < (AW+1)'(DEPTH - 1); // RULE_04
      // Shared sideband bits go to config when option on
      cfg_shared_out <= addr_space_id_capability_on ?
        bus.request_stream_sideband[SHARED_HI:SHARED_LO] : cfg_shared_in; // RULE_14
    end
  end

  // Queue writes on transfer
  always_ff @(posedge clk_w) begin
    if (take) begin
      seq_mem[idx(sq_wr)] <= bus.req_seq_in_a;
      if (bus.req_non_posted && !client_tag_on)
        tag_mem[idx(tq_wr)] <= tag_ctr;
    end
  end
endmodule

/* File: rtl/rts_client.sv */
// Client end: issues requests, pairs returned tags and echoed sequences in order.
// Assumes the core returns tags in transfer order.
`timescale 1ns/1ns
module rts_client
  import rts_pkg::*;
(
  rts_if.client bus,
  input wire logic user_valid, // User wants to send a beat
  input wire logic user_non_posted, // Beat is Non-Posted
  input wire logic [SIDEBAND_W-1:0] user_sideband, // Sideband to send
  output logic user_ready, // Beat taken last cycle
  output logic [TAG_W-1:0] matched_tag, // Last tag captured
  output logic matched_two, // Two tags captured last cycle
  output logic [SEQ_W-1:0] done_seq, // Latest echoed sequence
  output logic done_strobe // Echo seen last cycle
);
  logic [SEQ_W-1:0] seq_ctr, next_seq_ctr; // Sequence to attach
  logic [TAG_W-1:0] next_matched_tag;
  logic [SEQ_W-1:0] next_done_seq;
  logic took;

  assign took = bus.req_valid && bus.req_ready; // RULE_15
  assign bus.req_valid = user_valid; // RULE_04
  assign bus.req_non_posted = user_non_posted;
  assign bus.req_seq_in_a = seq_ctr; // RULE_08
  assign bus.request_stream_sideband = user_sideband; // RULE_14

  // Next values: later tag wins, since it is newer in order
  always_comb begin
    next_seq_ctr = took ? seq_ctr + 1'b1 : seq_ctr;
    next_matched_tag = matched_tag;
    if (bus.alloc_tag_strobe_b) next_matched_tag = bus.alloc_tag_out_b; // RULE_05
    else if (bus.alloc_tag_strobe_a) next_matched_tag = bus.alloc_tag_out_a; // RULE_03
    next_done_seq = done_seq;
    if (bus.echo_seq_strobe_b) next_done_seq = bus.echo_seq_out_b; // RULE_13
    else if (bus.echo_seq_strobe_a) next_done_seq = bus.echo_seq_out_a;
  end

  // Register client state
  always_ff @(posedge bus.clk or posedge bus.reset) begin
    if (bus.reset) begin
      seq_ctr <= SEQ_RST;
      matched_tag <= TAG_RST;
      matched_two <= 1'b0;
      done_seq <= SEQ_RST;
      done_strobe <= 1'b0;
      user_ready <= 1'b0;
    end else begin
      seq_ctr <= next_seq_ctr;
      matched_tag <= next_matched_tag;
      matched_two <= bus.alloc_tag_strobe_a && bus.alloc_tag_strobe_b;
      done_seq <= next_done_seq;
      done_strobe <= bus.echo_seq_strobe_a;
      user_ready <= took;
    end
  end
endmodule

/* File: sim/rts_chk.sv */
// Checker for the tag and sequence return path.
// Assumes it watches the signals of the interface joining both ends.
`timescale 1ns/1ns
module rts_chk
  import rts_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic client_tag_on,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_non_posted,
  input wire logic [TAG_W-1:0] alloc_tag_out_a,
  input wire logic [TAG_W-1:0] alloc_tag_out_b,
  input wire logic alloc_tag_strobe_a,
  input wire logic alloc_tag_strobe_b,
  input wire logic echo_seq_strobe_a,
  input wire logic echo_seq_strobe_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [TAG_W-1:0] exp_tag; // Next tag due
  logic np_xfer; // Non-Posted beat taken
  assign np_xfer = req_valid && req_ready && req_non_posted;
  // Tags run as a counter from zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exp_tag <= '0;
    end else begin
      exp_tag <= exp_tag + TAG_W'(alloc_tag_strobe_a) + TAG_W'(alloc_tag_strobe_b);
    end
  end
  property p_tag_order; alloc_tag_strobe_a |-> alloc_tag_out_a == exp_tag; endproperty
  a_tag_order: assert property (p_tag_order) else $error("tag out of order");
  property p_tag_pair; alloc_tag_strobe_b |-> alloc_tag_out_b == alloc_tag_out_a + 10'h001; endproperty
  a_tag_pair: assert property (p_tag_pair) else $error("second tag not the later one");
  property p_tag_b; alloc_tag_strobe_b |-> alloc_tag_strobe_a; endproperty
  a_tag_b: assert property (p_tag_b) else $error("second tag alone");
  property p_tag_soon; np_xfer && !client_tag_on |-> ##[1:20] alloc_tag_strobe_a; endproperty
  a_tag_soon: assert property (p_tag_soon) else $error("tag not returned");
  property p_client_tag; client_tag_on |-> !alloc_tag_strobe_a && !alloc_tag_strobe_b; endproperty
  a_client_tag: assert property (p_client_tag) else $error("tag strobe in client mode");
  property p_seq_soon; req_valid && req_ready |-> ##[2:20] echo_seq_strobe_a; endproperty
  a_seq_soon: assert property (p_seq_soon) else $error("sequence not echoed");
  property p_seq_b; echo_seq_strobe_b |-> echo_seq_strobe_a; endproperty
  a_seq_b: assert property (p_seq_b) else $error("second echo alone");
  property p_rst; disable iff (1'b0) reset |-> !(alloc_tag_strobe_a || echo_seq_strobe_a); endproperty
  a_rst: assert property (p_rst) else $error("strobe during reset");
endmodule

/* File: sim/rts_tb.sv */
// Testbench: both ends joined, random and corner traffic.
// Assumes one 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module rts_tb
  import rts_pkg::*;
;
  logic clk = 1'b0; // Bench clock
  logic reset = 1'b0; // Async reset, raised at time zero so it makes an edge
  logic [TAG_W-1:0] m_tag; // Tag the client captured
  logic [15:0] exp_match = '0; // Tag the client should capture
  logic match_due = 1'b0; // Capture to be checked next cycle
  logic client_tag_on = 1'b0; // Tag mode
  logic asid_on = 1'b0; // Shared sideband mode
  logic [45:0] cfg_in = '0; // Shared config value
  logic uv = 1'b0; // User valid
  logic unp = 1'b0; // User Non-Posted
  logic [SIDEBAND_W-1:0] usb = '0; // User sideband
  logic [15:0] tag_q[$]; // Tags owed
  logic [15:0] seq_q[$]; // Echoes owed
  logic [9:0] n_np; // Non-Posted count
  int total_checks = 0;
  int n_mismatch = 0;
  always #5 clk = ~clk;
  rts_if u_rts_if (.clk(clk), .reset(reset));
  rts_core #(.DEPTH(16), .LAT(3)) u_rts_core (.bus(u_rts_if.core), .client_tag_on(client_tag_on),
    .addr_space_id_capability_on(asid_on), .cfg_shared_in(cfg_in), .cfg_shared_out());
  rts_client u_rts_client (.bus(u_rts_if.client), .user_valid(uv), .user_non_posted(unp),
    .user_sideband(usb), .user_ready(), .matched_tag(m_tag), .matched_two(), .done_seq(), .done_strobe());
  rts_chk u_rts_chk (.clk(clk), .reset(reset), .client_tag_on(client_tag_on),
    .req_valid(u_rts_if.req_valid), .req_ready(u_rts_if.req_ready),
    .req_non_posted(u_rts_if.req_non_posted), .alloc_tag_out_a(u_rts_if.alloc_tag_out_a),
    .alloc_tag_out_b(u_rts_if.alloc_tag_out_b), .alloc_tag_strobe_a(u_rts_if.alloc_tag_strobe_a),
    .alloc_tag_strobe_b(u_rts_if.alloc_tag_strobe_b), .echo_seq_strobe_a(u_rts_if.echo_seq_strobe_a),
    .echo_seq_strobe_b(u_rts_if.echo_seq_strobe_b));
  // Compare and count
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Oldest owed value, unknown when none is owed
  function automatic logic [15:0] pop(ref logic [15:0] q[$]);
    return q.size() ? q.pop_front() : 16'hxxxx;
  endfunction
  // Monitor at the falling edge, where outputs are settled
  always @(negedge clk) begin
    if (reset) begin
      tag_q.delete();
      seq_q.delete();
      n_np = '0;
      match_due = 1'b0;
    end else begin
      if (match_due) chk("matched_tag", 16'(m_tag), exp_match);
      match_due = 1'b0;
      if (u_rts_if.alloc_tag_strobe_a) begin
        exp_match = pop(tag_q);
        chk("tag_a", 16'(u_rts_if.alloc_tag_out_a), exp_match);
        match_due = 1'b1;
      end
      if (u_rts_if.alloc_tag_strobe_b) begin
        exp_match = pop(tag_q);
        chk("tag_b", 16'(u_rts_if.alloc_tag_out_b), exp_match);
        match_due = 1'b1;
      end
      if (u_rts_if.echo_seq_strobe_a) chk("seq_a", 16'(u_rts_if.echo_seq_out_a), pop(seq_q));
      if (u_rts_if.echo_seq_strobe_b) chk("seq_b", 16'(u_rts_if.echo_seq_out_b), pop(seq_q));
      if (client_tag_on) chk("tag_strobes", 16'(u_rts_if.alloc_tag_strobe_a), 16'h0000);
    end
  end
  // Record transfers at the edge that takes them, before registers update
  always @(posedge clk) begin
    if (!reset && u_rts_if.req_valid && u_rts_if.req_ready) begin
      seq_q.push_back(16'(u_rts_if.req_seq_in_a));
      if (u_rts_if.req_non_posted && !client_tag_on) begin
        tag_q.push_back(16'(n_np));
        n_np = n_np + 10'h001;
      end
    end
  end
  // Random traffic, then drain and check nothing is left owed
  task automatic run(string nm, int n, int vp, int np);
    repeat (n) begin
      @(negedge clk);
      uv <= ($urandom % 100) < vp;
      unp <= ($urandom % 100) < np;
      usb <= SIDEBAND_W'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      cfg_in <= 46'({$urandom, $urandom});
      asid_on <= 1'($urandom);
    end
    @(negedge clk);
    uv <= 1'b0;
    repeat (40) @(negedge clk);
    chk("tags_left", 16'(tag_q.size()), 16'h0000);
    chk("seqs_left", 16'(seq_q.size()), 16'h0000);
    $display("%s done, %0d checks", nm, total_checks);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    void'($urandom(32'hbb4d4977));
    repeat (5) @(negedge clk);
    reset <= 1'b0;
    run("mixed", 300, 60, 50);
    run("np_burst", 40, 100, 100);
    run("posted", 40, 100, 0);
    uv <= 1'b1;
    unp <= 1'b1;
    repeat (4) @(negedge clk);
    reset <= 1'b1;
    repeat (2) @(negedge clk);
    reset <= 1'b0;
    run("after_reset", 60, 80, 50);
    client_tag_on <= 1'b1;
    run("client_tags", 60, 80, 80);
    report_and_stop();
  end
  // Watchdog: about fourteen times the expected run
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
